/* File: spioc_baud_gen.sv */
`timescale 1ns/1ps
module spioc_baud_gen (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // divider view
  spioc_cfg_if.baud cfg
);

  typedef struct packed {
    logic [2:0] pre_cnt;
    logic [spioc_pkg::HALF_CNT_W-1:0] rate_cnt;
    logic bit_clk;
    logic bit_edge;
  } spioc_baud_s;

  spioc_baud_s st_r;
  spioc_baud_s st_nxt;
  logic [7:0] half_limit;

  // ==========================================
  // prescaler then power of two divider
  always_comb begin
    st_nxt = st_r;
    st_nxt.bit_edge = 1'b0;
    half_limit = (spioc_pkg::HALF_BASE << cfg.rate_divide_code) - spioc_pkg::HALF_BASE;
    if (cfg.clk_run) begin
      if (st_r.pre_cnt >= cfg.prescale_code) begin
        st_nxt.pre_cnt = 3'h0;
        if ({1'b0, st_r.rate_cnt} >= half_limit) begin
          st_nxt.rate_cnt = '0;
          st_nxt.bit_clk = ~st_r.bit_clk;
          st_nxt.bit_edge = 1'b1;
        end else begin
          st_nxt.rate_cnt = st_r.rate_cnt + 7'h01;
        end
      end else begin
        st_nxt.pre_cnt = st_r.pre_cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cfg.bit_clk = st_r.bit_clk;
  assign cfg.bit_edge = st_r.bit_edge;

endmodule

/* File: spioc_cfg_if.sv */
`timescale 1ns/1ps
interface spioc_cfg_if;
  // configuration
  logic master_select;
  logic mode_fault_enable;
  logic bidir_output_enable;
  logic single_wire_select;
  logic select_output_enable;
  logic [2:0] prescale_code;
  logic [2:0] rate_divide_code;
  logic clk_run;
  // synchronised pins and shifter side
  logic mosi_s;
  logic miso_s;
  logic ss_s;
  logic tx_bit;
  logic ss_assert;
  // pin routing results
  logic mosi_o;
  logic mosi_oe;
  logic miso_o;
  logic miso_oe;
  logic ss_o;
  logic ss_oe;
  logic rx_bit;
  logic slave_select_n;
  logic mode_fault_n;
  logic mosi_gpio;
  logic miso_gpio;
  logic ss_gpio;
  // bit rate clock
  logic bit_clk;
  logic bit_edge;

  modport ctl (
    output master_select, mode_fault_enable, bidir_output_enable, single_wire_select,
    output select_output_enable, prescale_code, rate_divide_code, clk_run,
    output mosi_s, miso_s, ss_s, tx_bit, ss_assert,
    input mosi_o, mosi_oe, miso_o, miso_oe, ss_o, ss_oe, rx_bit,
    input slave_select_n, mode_fault_n, mosi_gpio, miso_gpio, ss_gpio,
    input bit_clk, bit_edge
  );
  modport mux (
    input master_select, mode_fault_enable, bidir_output_enable, single_wire_select,
    input select_output_enable, mosi_s, miso_s, ss_s, tx_bit, ss_assert,
    output mosi_o, mosi_oe, miso_o, miso_oe, ss_o, ss_oe, rx_bit,
    output slave_select_n, mode_fault_n, mosi_gpio, miso_gpio, ss_gpio
  );
  modport baud (
    input prescale_code, rate_divide_code, clk_run,
    output bit_clk, bit_edge
  );
endinterface

/* File: spioc_peer.sv */
`timescale 1ns/1ps
module spioc_peer (
  // design drive, select, slave out, master out
  input wire logic [2:0] o,
  input wire logic [2:0] oe,
  // far side drive
  input wire logic [2:0] pv,
  input wire logic [2:0] pe,
  // resolved levels
  output logic [2:0] pin
);
  // ==========
  // released lines rise to the pull-up
  assign pin = (oe & o) | (~oe & pe & pv) | (~oe & ~pe);
endmodule

/* File: spioc_pin_mux.sv */
`timescale 1ns/1ps
module spioc_pin_mux (
  // routing view
  spioc_cfg_if.mux cfg
);

  // ==========================================
  // data pins
  always_comb begin
    cfg.mosi_o = cfg.tx_bit;
    cfg.miso_o = cfg.tx_bit;
    cfg.mosi_oe = 1'b0;
    cfg.miso_oe = 1'b0;
    cfg.mosi_gpio = 1'b0;
    cfg.miso_gpio = 1'b0;
    cfg.rx_bit = 1'b0;
    if (cfg.single_wire_select) begin
      if (cfg.master_select) begin
        cfg.mosi_oe = cfg.bidir_output_enable;
        cfg.rx_bit = cfg.mosi_s;
        cfg.miso_gpio = 1'b1;
      end else begin
        cfg.miso_oe = cfg.bidir_output_enable;
        cfg.rx_bit = cfg.miso_s;
        cfg.mosi_gpio = 1'b1;
      end
    end else if (cfg.master_select) begin
      cfg.mosi_oe = 1'b1;
      cfg.rx_bit = cfg.miso_s;
    end else begin
      cfg.miso_oe = ~cfg.ss_s;
      cfg.rx_bit = cfg.mosi_s;
    end
  end

  // ==========================================
  // slave select pin
  always_comb begin
    cfg.ss_o = 1'b1;
    cfg.ss_oe = 1'b0;
    cfg.ss_gpio = 1'b0;
    cfg.slave_select_n = 1'b1;
    cfg.mode_fault_n = 1'b1;
    if (!cfg.master_select) begin
      cfg.slave_select_n = cfg.ss_s;
    end else if (!cfg.mode_fault_enable) begin
      cfg.ss_gpio = 1'b1;
    end else if (!cfg.select_output_enable) begin
      cfg.mode_fault_n = cfg.ss_s;
    end else begin
      cfg.ss_oe = 1'b1;
      cfg.ss_o = ~cfg.ss_assert;
    end
  end

endmodule

/* File: spioc_pkg.sv */
package spioc_pkg;

  // ==========================================
  // register map
  localparam logic [11:0] ADDR_OPTION = 12'h000;
  localparam logic [11:0] ADDR_RATE = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;

  // ==========================================
  // option control fields
  localparam int OPT_MODE_FAULT_BIT = 4;
  localparam int OPT_BIDIR_OE_BIT = 3;
  localparam int OPT_STOP_WAIT_BIT = 1;
  localparam int OPT_SINGLE_WIRE_BIT = 0;
  localparam logic [7:0] OPT_WRITE_MASK = 8'h1b;
  localparam logic [7:0] OPT_RESET = 8'h00;

  // ==========================================
  // bit rate select fields
  localparam int RATE_PRESCALE_LSB = 4;
  localparam int RATE_DIVIDE_LSB = 0;
  localparam int RATE_CODE_W = 3;
  localparam logic [7:0] RATE_WRITE_MASK = 8'h77;
  localparam logic [7:0] RATE_RESET = 8'h00;

  // ==========================================
  // flag status fields
  localparam int STAT_RX_FULL_BIT = 7;
  localparam int STAT_TX_EMPTY_BIT = 5;
  localparam int STAT_FAULT_BIT = 4;

  // ==========================================
  // bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HRESP_OKAY = 2'h0;

  // ==========================================
  // divider counters
  localparam int HALF_CNT_W = 7;
  localparam logic [7:0] HALF_BASE = 8'h01;

endpackage

/* File: spioc_sva.sv */
`timescale 1ns/1ps
module spioc_sva (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus answer
  input wire logic hreadyout,
  input wire logic [1:0] hresp,
  // core side
  input wire logic master_select,
  input wire logic select_output_enable,
  input wire logic wait_mode,
  input wire logic mode_fault_n,
  input wire logic clk_run,
  input wire logic bit_clk,
  input wire logic bit_edge,
  // pins
  input wire logic mosi_oe,
  input wire logic miso_oe,
  input wire logic mosi_gpio,
  input wire logic ss_oe
);
  // ==========
  // checks
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  a_bus_ready: assert property (hreadyout && hresp == spioc_pkg::HRESP_OKAY)
    else $error("bus answer not ready okay");
  a_slave_quiet: assert property ($past(!master_select) |-> !ss_oe && mode_fault_n)
    else $error("slave select pin not an input");
  a_fault_input: assert property (!mode_fault_n |->
    $past(master_select && !select_output_enable))
    else $error("fault input outside its mode");
  a_select_out: assert property (ss_oe |-> $past(master_select && select_output_enable))
    else $error("select driven outside its mode");
  a_one_driver: assert property (!(mosi_oe && miso_oe))
    else $error("both data pins driven");
  a_gpio_free: assert property (mosi_gpio |-> !mosi_oe)
    else $error("released pin still driven");
  a_wait_run: assert property (!wait_mode [*3] |-> clk_run)
    else $error("clocks stopped outside wait");
  a_halt_hold: assert property (!clk_run && $past(!clk_run) |-> $stable(bit_clk))
    else $error("bit clock moved while halted");
  a_edge_toggle: assert property (bit_edge |-> bit_clk != $past(bit_clk))
    else $error("edge pulse without toggle");
endmodule

/* File: spioc_top.sv */
`timescale 1ns/1ps
module spioc_top (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic [1:0] hresp,
  // core side
  input wire logic master_select,
  input wire logic select_output_enable,
  input wire logic wait_mode,
  input wire logic tx_bit,
  input wire logic ss_assert,
  input wire logic rx_full_flag,
  input wire logic tx_empty_flag,
  input wire logic mode_fault_flag,
  output logic rx_bit,
  output logic slave_select_n,
  output logic mode_fault_n,
  output logic clk_run,
  output logic bit_clk,
  output logic bit_edge,
  // general i/o release
  output logic mosi_gpio,
  output logic miso_gpio,
  output logic ss_gpio,
  // pins
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe,
  input wire logic ss_i,
  output logic ss_o,
  output logic ss_oe
);

  typedef struct packed {
    logic [7:0] option;
    logic [7:0] rate;
    logic wr_pend;
    logic [11:0] wr_addr;
    logic [31:0] rdata;
    logic readyout;
    logic [1:0] resp;
    logic mosi_meta;
    logic mosi_s;
    logic miso_meta;
    logic miso_s;
    logic ss_meta;
    logic ss_s;
    logic mosi_o;
    logic mosi_oe;
    logic miso_o;
    logic miso_oe;
    logic ss_o;
    logic ss_oe;
    logic rx_bit;
    logic slave_select_n;
    logic mode_fault_n;
    logic mosi_gpio;
    logic miso_gpio;
    logic ss_gpio;
    logic clk_run;
  } spioc_top_s;

  spioc_top_s st_r;
  spioc_top_s st_nxt;
  spioc_cfg_if cfg ();
  logic addr_phase;
  logic [7:0] status_val;

  // ==========================================
  // helper modules
  spioc_pin_mux u_mux (
    .cfg(cfg.mux)
  );

  spioc_baud_gen u_baud (
    .hclk(hclk),
    .hresetn(hresetn),
    .cfg(cfg.baud)
  );

  assign cfg.master_select = master_select;
  assign cfg.select_output_enable = select_output_enable;
  assign cfg.mode_fault_enable = st_r.option[spioc_pkg::OPT_MODE_FAULT_BIT];
  assign cfg.bidir_output_enable = st_r.option[spioc_pkg::OPT_BIDIR_OE_BIT];
  assign cfg.single_wire_select = st_r.option[spioc_pkg::OPT_SINGLE_WIRE_BIT];
  assign cfg.prescale_code =
    st_r.rate[spioc_pkg::RATE_PRESCALE_LSB +: spioc_pkg::RATE_CODE_W];
  assign cfg.rate_divide_code =
    st_r.rate[spioc_pkg::RATE_DIVIDE_LSB +: spioc_pkg::RATE_CODE_W];
  assign cfg.clk_run = st_r.clk_run;
  assign cfg.mosi_s = st_r.mosi_s;
  assign cfg.miso_s = st_r.miso_s;
  assign cfg.ss_s = st_r.ss_s;
  assign cfg.tx_bit = tx_bit;
  assign cfg.ss_assert = ss_assert;

  // ==========================================
  // next state
  always_comb begin
    st_nxt = st_r;
    status_val = 8'h00;
    addr_phase = hsel && hready && (htrans == spioc_pkg::HTRANS_NONSEQ);

    // data phase write
    if (st_r.wr_pend) begin
      if (st_r.wr_addr == spioc_pkg::ADDR_OPTION) begin
        st_nxt.option = hwdata[7:0] & spioc_pkg::OPT_WRITE_MASK;
      end else if (st_r.wr_addr == spioc_pkg::ADDR_RATE) begin
        st_nxt.rate = hwdata[7:0] & spioc_pkg::RATE_WRITE_MASK;
      end
    end

    // address phase
    st_nxt.wr_pend = addr_phase && hwrite;
    st_nxt.wr_addr = haddr[11:0];
    st_nxt.readyout = 1'b1;
    st_nxt.resp = spioc_pkg::HRESP_OKAY;
    status_val[spioc_pkg::STAT_RX_FULL_BIT] = rx_full_flag;
    status_val[spioc_pkg::STAT_TX_EMPTY_BIT] = tx_empty_flag;
    status_val[spioc_pkg::STAT_FAULT_BIT] = mode_fault_flag;
    if (addr_phase && !hwrite) begin
      if (haddr[11:0] == spioc_pkg::ADDR_OPTION) begin
        st_nxt.rdata = {24'h000000, st_nxt.option};
      end else if (haddr[11:0] == spioc_pkg::ADDR_RATE) begin
        st_nxt.rdata = {24'h000000, st_nxt.rate};
      end else if (haddr[11:0] == spioc_pkg::ADDR_STATUS) begin
        st_nxt.rdata = {24'h000000, status_val};
      end else begin
        st_nxt.rdata = 32'h00000000;
      end
    end

    // pin synchronisers
    st_nxt.mosi_meta = mosi_i;
    st_nxt.mosi_s = st_r.mosi_meta;
    st_nxt.miso_meta = miso_i;
    st_nxt.miso_s = st_r.miso_meta;
    st_nxt.ss_meta = ss_i;
    st_nxt.ss_s = st_r.ss_meta;

    // registered pin routing
    st_nxt.mosi_o = cfg.mosi_o;
    st_nxt.mosi_oe = cfg.mosi_oe;
    st_nxt.miso_o = cfg.miso_o;
    st_nxt.miso_oe = cfg.miso_oe;
    st_nxt.ss_o = cfg.ss_o;
    st_nxt.ss_oe = cfg.ss_oe;
    st_nxt.rx_bit = cfg.rx_bit;
    st_nxt.slave_select_n = cfg.slave_select_n;
    st_nxt.mode_fault_n = cfg.mode_fault_n;
    st_nxt.mosi_gpio = cfg.mosi_gpio;
    st_nxt.miso_gpio = cfg.miso_gpio;
    st_nxt.ss_gpio = cfg.ss_gpio;

    // interface clock gate
    st_nxt.clk_run = !(wait_mode && st_nxt.option[spioc_pkg::OPT_STOP_WAIT_BIT]);
  end

  // ==========================================
  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
      st_r.option <= spioc_pkg::OPT_RESET;
      st_r.rate <= spioc_pkg::RATE_RESET;
      st_r.readyout <= 1'b1;
      st_r.resp <= spioc_pkg::HRESP_OKAY;
      st_r.mosi_meta <= 1'b1;
      st_r.mosi_s <= 1'b1;
      st_r.miso_meta <= 1'b1;
      st_r.miso_s <= 1'b1;
      st_r.ss_meta <= 1'b1;
      st_r.ss_s <= 1'b1;
      st_r.mosi_o <= 1'b1;
      st_r.miso_o <= 1'b1;
      st_r.ss_o <= 1'b1;
      st_r.slave_select_n <= 1'b1;
      st_r.mode_fault_n <= 1'b1;
      st_r.clk_run <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================
  // outputs
  assign hrdata = st_r.rdata;
  assign hreadyout = st_r.readyout;
  assign hresp = st_r.resp;
  assign rx_bit = st_r.rx_bit;
  assign slave_select_n = st_r.slave_select_n;
  assign mode_fault_n = st_r.mode_fault_n;
  assign clk_run = st_r.clk_run;
  assign bit_clk = cfg.bit_clk;
  assign bit_edge = cfg.bit_edge;
  assign mosi_gpio = st_r.mosi_gpio;
  assign miso_gpio = st_r.miso_gpio;
  assign ss_gpio = st_r.ss_gpio;
  assign mosi_o = st_r.mosi_o;
  assign mosi_oe = st_r.mosi_oe;
  assign miso_o = st_r.miso_o;
  assign miso_oe = st_r.miso_oe;
  assign ss_o = st_r.ss_o;
  assign ss_oe = st_r.ss_oe;

endmodule

/* File: spioc_top_tb.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module spioc_top_tb;
  // ==========
  // signals
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdv;
  logic [1:0] htrans = 2'h0, hresp;
  logic [2:0] hsize = 3'h2, pv = 3'h7, pe = 3'h0;
  logic master_select = 1'b0, select_output_enable = 1'b0, wait_mode = 1'b0;
  logic tx_bit = 1'b0, ss_assert = 1'b0, b;
  logic rx_full_flag = 1'b0, tx_empty_flag = 1'b0, mode_fault_flag = 1'b0;
  logic hreadyout, rx_bit, slave_select_n, mode_fault_n, clk_run, bit_clk, bit_edge;
  logic mosi_gpio, miso_gpio, ss_gpio, mosi_o, mosi_oe, miso_o, miso_oe, ss_o, ss_oe;
  logic [19:0] e;
  logic [7:0] rt;
  logic [19:0] pt [10] = '{20'h5008b, 20'h5088b, 20'h5011b, 20'h5099b, 20'h71087,
    20'h41081, 20'h21962, 20'h01122, 20'h01042, 20'h11003};
  wire [2:0] pin;
  wire hready = hreadyout;
  wire mosi_i = pin[0];
  wire miso_i = pin[1];
  wire ss_i = pin[2];
  int num_errors = 0, tests_run = 0, cyc = 0;
  always #25 hclk = ~hclk;
  spioc_top spioc_top_i (.*);
  spioc_peer spioc_peer_i (.o({ss_o, miso_o, mosi_o}), .oe({ss_oe, miso_oe, mosi_oe}),
    .pv(pv), .pe(pe), .pin(pin));
  // ==========
  // tasks
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    hwrite <= w;
    htrans <= spioc_pkg::HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [7:0] x);
    xfer(1'b0, a, 8'h00);
    `CHK($sformatf("register %h", a), {24'h0, x}, rdv)
  endtask
  task automatic settle;
    repeat (5) @(posedge hclk);
  endtask
  task automatic gap(output int k);
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (bit_edge !== 1'b1 && k < 3000);
  endtask
  task automatic baud(input logic [2:0] p, input logic [2:0] r);
    int k;
    xfer(1'b1, spioc_pkg::ADDR_RATE, {1'b0, p, 1'b0, r});
    rchk(spioc_pkg::ADDR_RATE, {1'b0, p, 1'b0, r});
    gap(k);
    gap(k);
    gap(k);
    `CHK("half period", (int'(p) + 1) << r, k)
  endtask
  // ==========
  // timeout
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      wrap_up;
    end
  end
  // ==========
  // tests
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    rchk(spioc_pkg::ADDR_OPTION, 8'h00);
    rchk(spioc_pkg::ADDR_RATE, 8'h00);
    xfer(1'b1, spioc_pkg::ADDR_OPTION, 8'hff);
    rchk(spioc_pkg::ADDR_OPTION, 8'h1b);
    xfer(1'b1, spioc_pkg::ADDR_RATE, 8'hff);
    rchk(spioc_pkg::ADDR_RATE, 8'h77);
    rx_full_flag <= 1'b1;
    tx_empty_flag <= 1'b1;
    mode_fault_flag <= 1'b1;
    xfer(1'b1, spioc_pkg::ADDR_STATUS, 8'h00);
    rchk(spioc_pkg::ADDR_OPTION, 8'h1b);
    rchk(spioc_pkg::ADDR_STATUS, 8'hb0);
    rx_full_flag <= 1'b0;
    mode_fault_flag <= 1'b0;
    xfer(1'b1, spioc_pkg::ADDR_STATUS, 8'hff);
    rchk(spioc_pkg::ADDR_STATUS, 8'h20);
    xfer(1'b1, 12'h00c, 8'hff);
    rchk(12'h00c, 8'h00);
    $display("registers done");
    xfer(1'b1, spioc_pkg::ADDR_OPTION, 8'h00);
    for (int i = 0; i < 8; i++) baud(i[2:0], 3'h1);
    for (int i = 0; i < 8; i++) baud(3'h2, i[2:0]);
    $display("bit rate done");
    xfer(1'b1, spioc_pkg::ADDR_RATE, 8'h00);
    xfer(1'b1, spioc_pkg::ADDR_OPTION, 8'h02);
    wait_mode <= 1'b1;
    settle;
    `CHK("clock run", 1'b0, clk_run)
    b = bit_clk;
    repeat (20) @(posedge hclk);
    `CHK("held bit clock", b, bit_clk)
    xfer(1'b1, spioc_pkg::ADDR_OPTION, 8'h00);
    settle;
    `CHK("clock run", 1'b1, clk_run)
    wait_mode <= 1'b0;
    $display("wait done");
    for (int i = 0; i < 10; i++) begin
      for (int d = 0; d < 2; d++) begin
        e = pt[i];
        master_select <= e[18];
        select_output_enable <= e[17];
        tx_bit <= d[0];
        ss_assert <= d[0];
        pe <= {~e[2], ~e[6], ~e[7]};
        pv <= {e[16], d[0], d[0]};
        xfer(1'b1, spioc_pkg::ADDR_OPTION, e[15:8]);
        settle;
        rt = {mosi_oe, miso_oe, mosi_gpio, miso_gpio,
          ss_gpio, ss_oe, mode_fault_n, slave_select_n};
        `CHK("pin routing", e[7:0], rt)
        `CHK("data pins", {2{d[0]}}, pin[1:0])
        if (pe[e[18] ^ e[8]]) `CHK("rx bit", d[0], rx_bit)
        if (e[2]) `CHK("select out", ~d[0], ss_o)
      end
    end
    $display("pins done");
    wrap_up;
  end
endmodule
bind spioc_top spioc_sva spioc_sva_i (
  .hclk(hclk),
  .hresetn(hresetn),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .master_select(master_select),
  .select_output_enable(select_output_enable),
  .wait_mode(wait_mode),
  .mode_fault_n(mode_fault_n),
  .clk_run(clk_run),
  .bit_clk(bit_clk),
  .bit_edge(bit_edge),
  .mosi_oe(mosi_oe),
  .miso_oe(miso_oe),
  .mosi_gpio(mosi_gpio),
  .ss_oe(ss_oe)
);
